/* File: rtl/qtimer_defs.vh */
`ifndef QTIMER_DEFS_VH
`define QTIMER_DEFS_VH
// register indices on the plain port (byte addresses)
`define ADDR_CNT_A      3'h0
`define ADDR_CNT_B      3'h1
`define ADDR_CNT_C      3'h2
`define ADDR_CNT_D      3'h3
`define ADDR_CLK_SEL    3'h4
`define ADDR_CONFIG1    3'h5
`define ADDR_CONFIG2    3'h6
`define ADDR_RUN        3'h7
// first configuration register fields
`define CFG1_PWM0       0
`define CFG1_PWM1       1
`define CFG1_JOIN_AB    2
`define CFG1_JOIN_CD    3
`define CFG1_DIR_LSB    4
// second configuration register fields
`define CFG2_CAPF_LSB   4
`define CFG2_CAPS_LSB   6
// clock select codes
`define CKSEL_PIN       2'h0
`define CKSEL_FAST      2'h1
`define CKSEL_SLOW      2'h2
`define CKSEL_128       2'h3
// reset values
`define RST_RUN         4'h0
`define RST_CFG1        8'h00
`define RST_CFG2        8'h00
`define RST_CLK_SEL     8'h00
`endif

/* File: rtl/counter_slice.v */
`timescale 1ns/1ps
`default_nettype none
// one 8-bit up/down counter with compare, reload and a synchronous load request
module counter_slice (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       enable,
	input  wire       tick,
	input  wire       run,
	input  wire       up,
	input  wire [7:0] compare,
	input  wire       load_req,
	output reg  [7:0] count_q,
	output wire       at_end,
	output reg        hit_q
);
	// end of count: target when up, zero when down
	assign at_end = up ? (count_q == compare) : (count_q == 8'h00);

	// advance only on a qualified tick; a pending load lands on that tick
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else if (enable)
		begin
			hit_q <= 1'b0;
			if (run && tick)
			begin
				if (load_req)
					count_q <= up ? 8'h00 : compare;
				else if (at_end)
				begin
					hit_q   <= 1'b1;
					count_q <= up ? 8'h00 : compare;
				end
				else if (up)
					count_q <= count_q + 8'h01;
				else
					count_q <= count_q - 8'h01;
			end
		end
	end
endmodule // counter_slice
`default_nettype wire

/* File: rtl/quad_counter_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_defs.vh"
// How it works
// - each unjoined counter advances only while its run bit is set
// - joined pairs use run bit of A for B, C for D
// - counter register reads live or captured value, write sets compare
// - stopped counter freezes and ignores its pin edges
// - write in counter mode clears count (up) or loads compare (down)
// - write-caused count update may wait for first enabled clock edge
// - write in PWM mode changes only the compare value
// - mode change never alters the count
// - clock code 00 selects port A pin per counter
// - codes 01,10 pick internal clocks; 11 picks 128 Hz
// - up/down counter all; capture A,B only; PWM counts down
// - A and C low bytes, B and D high bytes when joined
// - pair A/B plain mode interrupt mapping, B0 ordinary pin
// - PWM 0 mapping unjoined and joined, pin B0
// - capture function makes B, and A unless PWM 0 is on, captured counters with capture interrupts
// - pair C/D mapping with and without PWM 1, pin B1
// - capture on/off may cause spurious interrupts
// - at end of count raise interrupt and reload
// - direction bit 0 down, 1 up
module quad_counter_timer (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       clk_en,
	input  wire [2:0] address,
	input  wire [7:0] write_data,
	input  wire       write_strobe,
	input  wire       read_strobe,
	output reg  [7:0] read_data,
	input  wire       ext_clock_pin_0,
	input  wire       ext_clock_pin_1,
	input  wire       ext_clock_pin_2,
	input  wire       ext_clock_pin_3,
	input  wire       rc_oscillator_clock,
	input  wire       rc_div4_clock,
	input  wire       clock_32_khz,
	input  wire       clock_1_khz,
	input  wire       clock_128_hz,
	input  wire       capture_event,
	input  wire       port_b_zero_in,
	input  wire       port_b_one_in,
	output reg        pwm_pin_zero,
	output reg        pwm_pin_one,
	output reg        interrupt_a,
	output reg        interrupt_b,
	output reg        interrupt_c,
	output reg        interrupt_d
);
	reg  [7:0] clock_select_register;
	reg  [7:0] first_configuration_register;
	reg  [7:0] second_configuration_register;
	reg  [3:0] counter_run_register;
	reg  [7:0] cmp_q [0:3];
	reg  [3:0] load_q;
	reg  [7:0] cap_q [0:1];
	reg        cap_prev_q;
	reg        pwm0_q;
	reg        pwm1_q;
	wire [3:0] tick;
	wire [3:0] at_end;
	wire [3:0] hit;
	wire [3:0] run_eff;
	wire [3:0] up_eff;
	wire [7:0] cnt [0:3];
	wire       join_pair_low;
	wire       join_pair_high;
	wire       pwm_out_zero_on;
	wire       pwm_out_one_on;
	wire [1:0] capture_function_field;
	wire       capture_on;
	wire [3:0] pins;
	wire [3:0] fast_clk;
	wire [3:0] slow_clk;
	wire       cap_edge;

	assign join_pair_low          = first_configuration_register[`CFG1_JOIN_AB];
	assign join_pair_high         = first_configuration_register[`CFG1_JOIN_CD];
	assign pwm_out_zero_on        = first_configuration_register[`CFG1_PWM0];
	assign pwm_out_one_on         = first_configuration_register[`CFG1_PWM1];
	assign capture_function_field = second_configuration_register[`CFG2_CAPF_LSB+1:`CFG2_CAPF_LSB];
	assign capture_on             = |capture_function_field;
	assign pins     = {ext_clock_pin_3, ext_clock_pin_2, ext_clock_pin_1, ext_clock_pin_0};
	assign fast_clk = {clock_32_khz, clock_32_khz, rc_oscillator_clock, rc_oscillator_clock};
	assign slow_clk = {clock_1_khz, clock_1_khz, rc_div4_clock, rc_div4_clock};
	// capture strobe: rising edge of the capture input
	assign cap_edge = capture_event & ~cap_prev_q;

	// joined high byte follows the low byte run bit
	assign run_eff[0] = counter_run_register[0];
	assign run_eff[1] = join_pair_low ? counter_run_register[0] : counter_run_register[1];
	assign run_eff[2] = counter_run_register[2];
	assign run_eff[3] = join_pair_high ? counter_run_register[2] : counter_run_register[3];

	// direction bit 1 up, 0 down; PWM forces down
	assign up_eff[0] = first_configuration_register[`CFG1_DIR_LSB] & ~pwm_out_zero_on;
	assign up_eff[1] = (join_pair_low ? first_configuration_register[`CFG1_DIR_LSB]
		: first_configuration_register[`CFG1_DIR_LSB+1]) & ~pwm_out_zero_on;
	assign up_eff[2] = first_configuration_register[`CFG1_DIR_LSB+2] & ~pwm_out_one_on;
	assign up_eff[3] = (join_pair_high ? first_configuration_register[`CFG1_DIR_LSB+2]
		: first_configuration_register[`CFG1_DIR_LSB+3]) & ~pwm_out_one_on;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gen_slice
			reg  sel_clk;
			reg  src_q;
			wire low_wrap;
			wire joined_hi;
			// code 00 takes the counter's own port A pin
			always @*
			begin
				case (clock_select_register[2*g+1:2*g])
					`CKSEL_PIN:  sel_clk = pins[g];
					`CKSEL_FAST: sel_clk = fast_clk[g];
					`CKSEL_SLOW: sel_clk = slow_clk[g];
					`CKSEL_128:  sel_clk = clock_128_hz;
					default:     sel_clk = 1'b0;
				endcase
			end
			// source edge detector; clock inputs are synchronous samples
			always @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
					src_q <= 1'b0;
				else if (clk_en)
					src_q <= sel_clk;
			end
			if (g == 1 || g == 3)
			begin : gen_hi
				assign joined_hi = (g == 1) ? join_pair_low : join_pair_high;
				// a high load lands together with the low load, so both bytes start as one
				assign low_wrap  = tick[g-1] & (at_end[g-1] | (load_q[g-1] & load_q[g]));
			end
			else
			begin : gen_lo
				assign joined_hi = 1'b0;
				assign low_wrap  = 1'b0;
			end
			// joined high byte only moves on low byte wrap or on a load shared with the low byte
			assign tick[g] = joined_hi ? low_wrap : (sel_clk & ~src_q);
			// run gating freezes state and drops edges
			counter_slice u_slice (
				.clock    (clock),
				.rst_n    (rst_n),
				.enable   (clk_en),
				.tick     (tick[g]),
				.run      (run_eff[g]),
				.up       (up_eff[g]),
				.compare  (cmp_q[g]),
				.load_req (load_q[g]),
				.count_q  (cnt[g]),
				.at_end   (at_end[g]),
				.hit_q    (hit[g])
			);
		end
	endgenerate

	// software registers and write side effects
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clock_select_register         <= `RST_CLK_SEL;
			first_configuration_register  <= `RST_CFG1;
			second_configuration_register <= `RST_CFG2;
			counter_run_register          <= `RST_RUN;
			cmp_q[0] <= 8'h00;
			cmp_q[1] <= 8'h00;
			cmp_q[2] <= 8'h00;
			cmp_q[3] <= 8'h00;
			load_q   <= 4'h0;
		end
		else if (clk_en)
		begin
			// pending load clears only when its tick lands
			load_q <= load_q & ~(tick & run_eff);
			if (write_strobe)
			begin
				case (address)
					`ADDR_CNT_A, `ADDR_CNT_B, `ADDR_CNT_C, `ADDR_CNT_D:
					begin
						cmp_q[address[1:0]] <= write_data;
						if (!((address[1:0] == 2'h0 && pwm_out_zero_on) ||
							(address[1:0] == 2'h2 && pwm_out_one_on) ||
							(address[1:0] == 2'h1 && pwm_out_zero_on && join_pair_low) ||
							(address[1:0] == 2'h3 && pwm_out_one_on && join_pair_high)))
							load_q[address[1:0]] <= 1'b1;
					end
					`ADDR_CLK_SEL: clock_select_register <= write_data;
					`ADDR_CONFIG1: first_configuration_register <= write_data;
					`ADDR_CONFIG2: second_configuration_register <= write_data;
					`ADDR_RUN:     counter_run_register <= write_data[3:0];
					default:       counter_run_register <= counter_run_register;
				endcase
			end
		end
	end

	// capture of A and B on the capture strobe
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_prev_q <= 1'b0;
			cap_q[0]   <= 8'h00;
			cap_q[1]   <= 8'h00;
		end
		else if (clk_en)
		begin
			cap_prev_q <= capture_event;
			// only A and B can be captured; A skipped in PWM
			if (capture_on && cap_edge)
			begin
				if (!pwm_out_zero_on)
					cap_q[0] <= cnt[0];
				cap_q[1] <= cnt[1];
			end
		end
	end

	// PWM compare outputs, high while count is below the compare value
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm0_q <= 1'b0;
			pwm1_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pwm0_q <= join_pair_low ? ({cnt[1], cnt[0]} < {cmp_q[1], cmp_q[0]})
				: (cnt[0] < cmp_q[0]);
			pwm1_q <= join_pair_high ? ({cnt[3], cnt[2]} < {cmp_q[3], cmp_q[2]})
				: (cnt[2] < cmp_q[2]);
		end
	end

	// interrupt and pin mapping per pair
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			interrupt_a  <= 1'b0;
			interrupt_b  <= 1'b0;
			interrupt_c  <= 1'b0;
			interrupt_d  <= 1'b0;
			pwm_pin_zero <= 1'b0;
			pwm_pin_one  <= 1'b0;
		end
		else if (clk_en)
		begin
			// pair A/B mapping, capture events win
			// toggling capture may pulse the capture channels
			if (capture_on)
			begin
				interrupt_a <= cap_edge & ~pwm_out_zero_on;
				interrupt_b <= cap_edge;
			end
			else if (pwm_out_zero_on)
			begin
				interrupt_a <= 1'b0;
				interrupt_b <= hit[1] & ~join_pair_low;
			end
			else
			begin
				// joined pair ends when high byte wraps
				interrupt_a <= join_pair_low ? hit[1] : hit[0];
				interrupt_b <= hit[1] & ~join_pair_low;
			end
			if (pwm_out_one_on)
				interrupt_c <= 1'b0;
			else
				interrupt_c <= join_pair_high ? hit[3] : hit[2];
			interrupt_d  <= hit[3] & ~join_pair_high;
			pwm_pin_zero <= pwm_out_zero_on ? pwm0_q : port_b_zero_in;
			pwm_pin_one  <= pwm_out_one_on ? pwm1_q : port_b_one_in;
		end
	end

	// read port, data valid the cycle after the strobe
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			read_data <= 8'h00;
		else if (clk_en)
		begin
			read_data <= 8'h00;
			if (read_strobe)
			begin
				case (address)
					// captured value replaces live count on A and B
					`ADDR_CNT_A:   read_data <= capture_on ? cap_q[0] : cnt[0];
					`ADDR_CNT_B:   read_data <= capture_on ? cap_q[1] : cnt[1];
					`ADDR_CNT_C:   read_data <= cnt[2];
					`ADDR_CNT_D:   read_data <= cnt[3];
					`ADDR_CLK_SEL: read_data <= clock_select_register;
					`ADDR_CONFIG1: read_data <= first_configuration_register;
					`ADDR_CONFIG2: read_data <= second_configuration_register;
					`ADDR_RUN:     read_data <= {4'h0, counter_run_register};
					default:       read_data <= 8'h00;
				endcase
			end
		end
	end
endmodule // quad_counter_timer
`default_nettype wire

/* File: test/qtimer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_defs.vh"
module qtimer_checker (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic [2:0] address,
	input wire logic [7:0] write_data,
	input wire logic       write_strobe,
	input wire logic       read_strobe,
	input wire logic [7:0] read_data,
	input wire logic       port_b_zero_in,
	input wire logic       port_b_one_in,
	input wire logic       pwm_pin_zero,
	input wire logic       pwm_pin_one,
	input wire logic       interrupt_a,
	input wire logic       interrupt_b,
	input wire logic       interrupt_c,
	input wire logic       interrupt_d
);
	logic [7:0] cfg1_q;
	logic [1:0] capf_q;
	logic [3:0] run_q;
	logic [2:0] quiet_q;
	logic       calm;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// shadow of mode registers; quiet count lets pipelined pulses drain
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
		begin
			cfg1_q <= 8'h00;
			capf_q <= 2'h0;
			run_q <= 4'h0;
			quiet_q <= 3'h0;
		end
		else if (clk_en && write_strobe)
		begin
			quiet_q <= 3'h0;
			if (address == `ADDR_CONFIG1) cfg1_q <= write_data;
			if (address == `ADDR_CONFIG2) capf_q <= write_data[5:4];
			if (address == `ADDR_RUN) run_q <= write_data[3:0];
		end
		else if (quiet_q != 3'h7)
			quiet_q <= quiet_q + 3'h1;
	assign calm = (quiet_q == 3'h7);
	property p_rd_idle; $past(clk_en) && !$past(read_strobe) |-> read_data == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_pin0; calm && !cfg1_q[0] && $stable(port_b_zero_in) |=> pwm_pin_zero == $past(port_b_zero_in, 2); endproperty
	a_pin0: assert property (p_pin0) else $error("pin zero not plain");
	property p_pin1; calm && !cfg1_q[1] && $stable(port_b_one_in) |=> pwm_pin_one == $past(port_b_one_in, 2); endproperty
	a_pin1: assert property (p_pin1) else $error("pin one not plain");
	property p_pulse; interrupt_a || interrupt_c |=> !interrupt_a && !interrupt_c; endproperty
	a_pulse: assert property (p_pulse) else $error("interrupt too long");
	property p_pwm0; calm && cfg1_q[0] |-> !interrupt_a; endproperty
	a_pwm0: assert property (p_pwm0) else $error("interrupt a with pwm");
	property p_jab; calm && cfg1_q[2] && !cfg1_q[0] && capf_q == 2'h0 |-> !interrupt_b; endproperty
	a_jab: assert property (p_jab) else $error("interrupt b when joined");
	property p_jcd; calm && cfg1_q[3] |-> !interrupt_d; endproperty
	a_jcd: assert property (p_jcd) else $error("interrupt d when joined");
	property p_pwm1; calm && cfg1_q[1] |-> !interrupt_c; endproperty
	a_pwm1: assert property (p_pwm1) else $error("interrupt c with pwm");
	property p_stop; calm && run_q == 4'h0 && capf_q == 2'h0 |-> !(interrupt_a || interrupt_b
		|| interrupt_c || interrupt_d); endproperty
	a_stop: assert property (p_stop) else $error("interrupt while stopped");
	c_irq: cover property (interrupt_a);
	c_join: cover property (cfg1_q[2] && interrupt_a);
	c_pwm: cover property (cfg1_q[0] && pwm_pin_zero);
endmodule // qtimer_checker
bind quad_counter_timer qtimer_checker i_chk (.clock, .rst_n, .clk_en, .address, .write_data,
	.write_strobe, .read_strobe, .read_data, .port_b_zero_in, .port_b_one_in, .pwm_pin_zero,
	.pwm_pin_one, .interrupt_a, .interrupt_b, .interrupt_c, .interrupt_d);
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        write_strobe = 1'b0;
	logic        read_strobe = 1'b0;
	logic [2:0]  address = 3'h0;
	logic [7:0]  write_data = 8'h00;
	logic [7:0]  read_data, rv, c;
	logic [3:0]  ext_q = 4'h0;
	logic [3:0]  irq;
	logic [7:0]  div_q = 8'h00;
	logic [7:0]  ex [4];
	logic        pin0, pin1, up;
	logic        en = 1'b1;
	logic [31:0] seed = 32'h547b80d7;
	int          mismatches = 0;
	int          total_checks = 0;
	int          icnt [4] = '{0, 0, 0, 0};
	int          n, b;
	quad_counter_timer i_dut (.clock, .rst_n, .clk_en(en), .address, .write_data,
		.write_strobe, .read_strobe, .read_data, .ext_clock_pin_0(ext_q[0]),
		.ext_clock_pin_1(ext_q[1]), .ext_clock_pin_2(ext_q[2]), .ext_clock_pin_3(ext_q[3]),
		.rc_oscillator_clock(div_q[0]), .rc_div4_clock(div_q[2]), .clock_32_khz(div_q[3]),
		.clock_1_khz(div_q[4]), .clock_128_hz(div_q[5]), .capture_event(1'b0),
		.port_b_zero_in(div_q[3]), .port_b_one_in(div_q[4]), .pwm_pin_zero(pin0),
		.pwm_pin_one(pin1), .interrupt_a(irq[0]), .interrupt_b(irq[1]),
		.interrupt_c(irq[2]), .interrupt_d(irq[3]));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// first tick loads, then steps; wraps after compare + 1 steps
	function automatic logic [7:0] model(input logic u, input logic [7:0] m, input int k);
		return u ? 8'((k - 1) % (m + 1)) : 8'(m - (k - 1) % (m + 1));
	endfunction
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		write_strobe <= 1'b1;
		address <= a;
		write_data <= d;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clock);
		read_strobe <= 1'b1;
		address <= a;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 rv = read_data;
	endtask
	// pin edges two cycles apart so the sampler never misses one
	task automatic ticks(input int k, input int m);
		repeat (m)
		begin
			@(posedge clock);
			ext_q[k] <= 1'b1;
			repeat (2) @(posedge clock);
			ext_q[k] <= 1'b0;
			@(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask
	task automatic close_out();
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
		forever #12.5 clock = ~clock;
	// free-running source for internal clocks and plain port b values
	always @(posedge clock)
	begin
		div_q <= div_q + 8'h01;
		foreach (icnt[i]) icnt[i] += int'(irq[i] === 1'b1);
	end
	initial
	begin
		#200us;
		mismatches++;
		close_out();
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		for (int a = 4; a < 8; a++)
		begin
			rd(3'(a));
			`CHK("reset", 8'h00, rv)
		end
		// clock enable low must swallow a write
		en <= 1'b0;
		wr(6, 8'h30);
		en <= 1'b1;
		rd(6);
		`CHK("frozen bus", 8'h00, rv)
		// clock source set while all stopped
		wr(4, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			c = 8'h01 + 8'(seed[3:0]);
			up = seed[4];
			n = 1 + int'(seed[10:5]);
			if (n % (c + 1) == 0) n++;
			wr(5, 8'(up) << (4 + k));
			wr(3'(k), c);
			wr(7, 8'h01 << k);
			b = icnt[k];
			ticks(k, n);
			wr(7, 8'h00);
			ex[k] = model(up, c, n);
			rd(3'(k));
			`CHK("count", ex[k], rv)
			`CHK("irqs", n / (c + 1), icnt[k] - b)
			ticks(k, 3);
			rd(3'(k));
			`CHK("frozen", ex[k], rv)
		end
		// pwm on both outputs while stopped: counts must hold
		// modes switched only while stopped
		seed = lfsr(seed);
		wr(5, 8'h03);
		wr(0, seed[7:0]);
		wr(2, seed[15:8]);
		rd(0);
		`CHK("pwm write", ex[0], rv)
		rd(2);
		`CHK("mode change", ex[2], rv)
		repeat (4) @(posedge clock);
		#1;
		`CHK("pin zero", ex[0] < seed[7:0], pin0)
		`CHK("pin one", ex[2] < seed[15:8], pin1)
		// joined pair with only the low run bit set
		wr(5, 8'h1c);
		wr(0, 8'hff);
		wr(1, 8'hff);
		wr(7, 8'h01);
		ticks(0, 300);
		wr(7, 8'h00);
		rd(0);
		`CHK("joined low", 8'h2b, rv)
		rd(1);
		`CHK("joined high", 8'h01, rv)
		close_out();
	end
endmodule // tb_top
`default_nettype wire
